/* File: rtl/fic_pkg.sv */
package fic_pkg;
  // register byte addresses on the apb bus
  localparam logic [7:0] OFS_CTRL_MAIN = 8'h00;
  localparam logic [7:0] OFS_RST_PAT = 8'h04;
  localparam logic [7:0] OFS_BUF_CLR = 8'h08;
  localparam logic [7:0] OFS_ADDR_LO = 8'h0c;
  localparam logic [7:0] OFS_ADDR_HI = 8'h10;
  localparam logic [7:0] OFS_DATA_BASE = 8'h14;
  localparam logic [7:0] OFS_FLASH_WIN = 8'h40;
  localparam int PAGE_WORDS = 32;
  localparam int PAGES = 128;
  localparam int FLASH_WORDS = 4096;
  localparam int ADDR_W = 12;
  localparam int OFF_W = 5;
  localparam logic [4:0] OFF_LAST = 5'h1f;
  localparam logic [7:0] CHIP_RST_KEY = 8'h55;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [15:0] PAT1 = 16'h5a5a;
  localparam logic [15:0] PAT2 = 16'ha5a5;
  localparam logic [15:0] PAT3 = 16'h3c3c;
  localparam int CLK_HZ = 10000000;
  localparam int PROC_TIME_US = 50;
  localparam int PROC_CYC = PROC_TIME_US * (CLK_HZ / 1000000);
  localparam int BIT_EWEN = 7;
  localparam int BIT_MODE = 4;
  localparam int BIT_TRIG = 3;
  localparam int BIT_WT = 2;
  localparam int BIT_RDEN = 1;
  localparam int BIT_RD = 0;
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_ENABLE = 3'h6;
  typedef enum logic [2:0] {
    FIC_IDLE = 3'h0,
    FIC_ERASE = 3'h1,
    FIC_WRITE = 3'h2,
    FIC_READ = 3'h3,
    FIC_CLEAR = 3'h4
  } fic_state_type;
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [7:0] wdata;
  } fic_req_type;
endpackage

/* File: rtl/fic_ctrl.sv */
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1: erase and write act on 32-word pages, read on single words
// R2: firmware erases a page before writing it
// R3: enabled status set after correct patterns; buffer loads only while it is set
// R4: write-start bit stays high during the write and clears at its end
// R5: read needs read enable, then read-start; read-start clears when done
// R6: address bits 11..5 pick the page, bits 4..0 the word
// R7: buffer-clear bit clears itself once the buffer is cleared
// R8: firmware clears the buffer before first use and before updates
// R9: buffer maps onto the page picked by address bits 11..5
// R10: data0 high write loads the word into the buffer and bumps the address
// R11: the address holds at the last word of the page
// R12: the buffer clears itself after a page write
// R13: on bad verify firmware clears and reloads the buffer
// R14: address low holds bits 7..0, high holds 11..8, upper nibble reads zero
// R15: two address, four 16-bit data pairs, three control registers, 16-bit moves
// R16: mode 000 write, 001 erase, 011 read, 110 enable, others reserved
// R17: trigger starts a timer; trigger clears when the timer runs out
// R18: writing one to enabled status does nothing, writing zero clears it
// R19: writing 55h to the chip reset pattern register pulses a chip reset
// R20: a finished read places the word into data pair zero
module fic_ctrl (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic CHIP_RESET,
  output logic BUSY
);
  localparam logic [15:0] PROC_CNT = 16'(fic_pkg::PROC_CYC);
  localparam logic [4:0] WORD_ONE = 5'h01;

  logic [15:0] flash_mem [fic_pkg::FLASH_WORDS];
  logic [15:0] wbuf [fic_pkg::PAGE_WORDS];
  logic [31:0] wbuf_valid;
  logic [7:0] ctrl;
  logic [7:0] rst_pat;
  logic clr_bit;
  logic [11:0] faddr;
  logic [15:0] dpair [4];
  logic [15:0] tmr;
  fic_pkg::fic_state_type state;
  fic_pkg::fic_req_type req;
  logic acc;
  logic wr;
  logic patterns_ok;
  logic [6:0] page;

  assign req = '{addr: PADDR[7:0], write: PWRITE, wdata: PWDATA[7:0]};
  assign acc = PSEL && PENABLE;
  assign wr = acc && req.write;
  assign page = faddr[11:5]; // R6 R9
  assign patterns_ok = dpair[1] == fic_pkg::PAT1 && dpair[2] == fic_pkg::PAT2
    && dpair[3] == fic_pkg::PAT3;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = a == ofs;
  endfunction

  // data register index for a byte address in the data window, or 8 if none
  function automatic logic [3:0] dsel(input logic [7:0] a);
    logic [7:0] d;
    d = a - fic_pkg::OFS_DATA_BASE;
    if (a >= fic_pkg::OFS_DATA_BASE && d[7:2] < 6'h08)
      dsel = {1'b0, d[4:2]};
    else
      dsel = 4'h8;
  endfunction

  logic [3:0] ds;
  assign ds = dsel(req.addr);

  // apb answers in the access phase without wait states
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      PREADY <= 1'b0;
    else
      PREADY <= PSEL && !PENABLE;
  end

  logic ok_addr;
  assign ok_addr = req.addr <= fic_pkg::OFS_ADDR_HI || ds != 4'h8;

  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0;
    if (hit(req.addr, fic_pkg::OFS_CTRL_MAIN))
      next_rdata[7:0] = ctrl;
    else if (hit(req.addr, fic_pkg::OFS_RST_PAT))
      next_rdata[7:0] = rst_pat;
    else if (hit(req.addr, fic_pkg::OFS_BUF_CLR))
      next_rdata[0] = clr_bit;
    else if (hit(req.addr, fic_pkg::OFS_ADDR_LO))
      next_rdata[7:0] = faddr[7:0]; // R14
    else if (hit(req.addr, fic_pkg::OFS_ADDR_HI))
      next_rdata[3:0] = faddr[11:8]; // R14
    else if (ds != 4'h8)
      next_rdata[7:0] = ds[0] ? dpair[ds[2:1]][15:8] : dpair[ds[2:1]][7:0]; // R15
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PRDATA <= (PSEL && !PENABLE) ? next_rdata : PRDATA;
      PSLVERR <= PSEL && !PENABLE && !(PADDR[31:8] == 24'h0 && ok_addr);
    end
  end

  logic bus_ok;
  assign bus_ok = wr && PREADY && !PSLVERR;

  logic ld_word;
  assign ld_word = bus_ok && ds == 4'h1 && ctrl[fic_pkg::BIT_EWEN]; // R3 R10

  // chip reset pattern and one-cycle reset pulse
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_pat <= 8'h0;
      CHIP_RESET <= 1'b0;
    end
    else
    begin
      if (bus_ok && hit(req.addr, fic_pkg::OFS_RST_PAT))
        rst_pat <= req.wdata;
      CHIP_RESET <= bus_ok && hit(req.addr, fic_pkg::OFS_RST_PAT)
        && req.wdata == fic_pkg::CHIP_RST_KEY; // R19
    end
  end

  // address register with auto increment held at page end
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      faddr <= 12'h0; // R14
    else if (bus_ok && hit(req.addr, fic_pkg::OFS_ADDR_LO))
      faddr[7:0] <= req.wdata;
    else if (bus_ok && hit(req.addr, fic_pkg::OFS_ADDR_HI))
      faddr[11:8] <= req.wdata[3:0]; // R14
    else if (ld_word && faddr[4:0] != fic_pkg::OFF_LAST)
      faddr <= faddr + {7'h0, WORD_ONE}; // R10 R11
  end

  // data pairs; a read result lands in pair zero
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      for (int i = 0; i < 4; i++)
        dpair[i] <= 16'h0;
    end
    else if (state == fic_pkg::FIC_READ)
      dpair[0] <= flash_mem[faddr]; // R20 R15
    else if (bus_ok && ds != 4'h8)
    begin
      if (ds[0])
        dpair[ds[2:1]][15:8] <= req.wdata;
      else
        dpair[ds[2:1]][7:0] <= req.wdata;
    end
  end

  // write buffer fill and clear
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      wbuf_valid <= 32'h0;
    else if (state == fic_pkg::FIC_CLEAR || (state == fic_pkg::FIC_WRITE && tmr == 16'h0))
      wbuf_valid <= 32'h0; // R7 R12
    else if (ld_word)
    begin
      wbuf_valid[faddr[4:0]] <= 1'b1; // R9
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (ld_word)
      wbuf[faddr[4:0]] <= {req.wdata, dpair[0][7:0]}; // R10
  end

  // control register, timer and sequencer
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      ctrl <= 8'h0;
      clr_bit <= 1'b0;
      tmr <= 16'h0;
      state <= fic_pkg::FIC_IDLE;
    end
    else
    begin
      if (bus_ok && hit(req.addr, fic_pkg::OFS_BUF_CLR) && req.wdata[0])
        clr_bit <= 1'b1;
      if (bus_ok && hit(req.addr, fic_pkg::OFS_CTRL_MAIN))
      begin
        ctrl[6:0] <= req.wdata[6:0];
        if (!req.wdata[fic_pkg::BIT_EWEN])
          ctrl[fic_pkg::BIT_EWEN] <= 1'b0; // R18
        if (req.wdata[fic_pkg::BIT_TRIG] && !ctrl[fic_pkg::BIT_TRIG])
          tmr <= PROC_CNT; // R17
      end
      // enable procedure window
      if (ctrl[fic_pkg::BIT_TRIG] && state == fic_pkg::FIC_IDLE)
      begin
        if (ctrl[6:4] == fic_pkg::MODE_ENABLE && patterns_ok)
        begin
          ctrl[fic_pkg::BIT_EWEN] <= 1'b1; // R3
          ctrl[fic_pkg::BIT_TRIG] <= 1'b0;
        end
        else if (tmr == 16'h0)
          ctrl[fic_pkg::BIT_TRIG] <= 1'b0; // R17
        else
          tmr <= tmr - 16'h1;
      end
      unique case (state)
        fic_pkg::FIC_IDLE:
        begin
          if (clr_bit)
            state <= fic_pkg::FIC_CLEAR;
          else if (ctrl[fic_pkg::BIT_WT] && ctrl[fic_pkg::BIT_EWEN]
            && ctrl[6:4] == fic_pkg::MODE_WRITE)
          begin
            state <= fic_pkg::FIC_WRITE; // R4 R16
            tmr <= PROC_CNT;
          end
          else if (ctrl[fic_pkg::BIT_WT] && ctrl[fic_pkg::BIT_EWEN]
            && ctrl[6:4] == fic_pkg::MODE_ERASE)
          begin
            state <= fic_pkg::FIC_ERASE; // R16
            tmr <= PROC_CNT;
          end
          else if (ctrl[fic_pkg::BIT_RD] && ctrl[fic_pkg::BIT_RDEN]
            && ctrl[6:4] == fic_pkg::MODE_READ)
            state <= fic_pkg::FIC_READ; // R5 R16
        end
        fic_pkg::FIC_ERASE, fic_pkg::FIC_WRITE:
        begin
          if (tmr != 16'h0)
            tmr <= tmr - 16'h1;
          else
          begin
            ctrl[fic_pkg::BIT_WT] <= 1'b0; // R4
            state <= fic_pkg::FIC_IDLE;
          end
        end
        fic_pkg::FIC_READ:
        begin
          ctrl[fic_pkg::BIT_RD] <= 1'b0; // R5
          state <= fic_pkg::FIC_IDLE;
        end
        fic_pkg::FIC_CLEAR:
        begin
          clr_bit <= 1'b0; // R7
          state <= fic_pkg::FIC_IDLE;
        end
      endcase
    end
  end

  // flash array, whole page erase and page write
  always_ff @(posedge CLOCK)
  begin
    if ((state == fic_pkg::FIC_ERASE || state == fic_pkg::FIC_WRITE) && tmr == 16'h0)
    begin
      for (int w = 0; w < fic_pkg::PAGE_WORDS; w++)
      begin
        if (state == fic_pkg::FIC_ERASE)
          flash_mem[{page, 5'(w)}] <= fic_pkg::ERASED_WORD; // R1
        else if (wbuf_valid[w])
          flash_mem[{page, 5'(w)}] <= flash_mem[{page, 5'(w)}] & wbuf[w]; // R1 R2
      end
    end
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      BUSY <= 1'b0;
    else
      BUSY <= state != fic_pkg::FIC_IDLE;
  end

  sequence s_rst_pulse;
    CHIP_RESET ##1 !CHIP_RESET;
  endsequence

  sequence s_read_done;
    !ctrl[fic_pkg::BIT_RD] && state == fic_pkg::FIC_IDLE;
  endsequence

  a_write_clears: assert property (@(posedge CLOCK) disable iff (!NRST) // R4
    (state == fic_pkg::FIC_WRITE && tmr == 16'h0) |=> !ctrl[fic_pkg::BIT_WT])
    else $error("write bit not cleared");
  a_read_clears: assert property (@(posedge CLOCK) disable iff (!NRST) // R5
    state == fic_pkg::FIC_READ |=> s_read_done)
    else $error("read bit not cleared");
  a_addr_holds_end: assert property (@(posedge CLOCK) disable iff (!NRST) // R11
    (ld_word && faddr[4:0] == fic_pkg::OFF_LAST) |=> $stable(faddr))
    else $error("address passed page end");
  a_addr_bumps: assert property (@(posedge CLOCK) disable iff (!NRST) // R10
    (ld_word && faddr[4:0] != fic_pkg::OFF_LAST) |=> faddr == $past(faddr) + 12'h1)
    else $error("address not incremented");
  a_load_needs_en: assert property (@(posedge CLOCK) disable iff (!NRST) // R3
    $rose(wbuf_valid != 32'h0) |-> $past(ctrl[fic_pkg::BIT_EWEN]))
    else $error("buffer loaded while disabled");
  a_clear_done: assert property (@(posedge CLOCK) disable iff (!NRST) // R7
    state == fic_pkg::FIC_CLEAR |=> !clr_bit && wbuf_valid == 32'h0)
    else $error("buffer clear incomplete");
  a_buf_after_wr: assert property (@(posedge CLOCK) disable iff (!NRST) // R12
    (state == fic_pkg::FIC_WRITE && tmr == 16'h0) |=> wbuf_valid == 32'h0)
    else $error("buffer kept after write");
  a_chip_rst: assert property (@(posedge CLOCK) disable iff (!NRST) // R19
    (bus_ok && hit(req.addr, fic_pkg::OFS_RST_PAT) && req.wdata == fic_pkg::CHIP_RST_KEY)
    |=> s_rst_pulse)
    else $error("chip reset pulse wrong");
  a_ewen_no_set: assert property (@(posedge CLOCK) disable iff (!NRST) // R18
    $rose(ctrl[fic_pkg::BIT_EWEN]) |-> $past(ctrl[fic_pkg::BIT_TRIG] && patterns_ok))
    else $error("enabled status set by software");
  a_hi_nibble: assert property (@(posedge CLOCK) disable iff (!NRST) // R14
    (PSEL && !PENABLE && hit(req.addr, fic_pkg::OFS_ADDR_HI)) |=> PRDATA[7:4] == 4'h0)
    else $error("high address upper nibble nonzero");
  a_pready_access: assert property (@(posedge CLOCK) disable iff (!NRST) // R15
    (PSEL && !PENABLE) |=> PREADY)
    else $error("no ready in access phase");
  a_slverr_unmapped: assert property (@(posedge CLOCK) disable iff (!NRST) // R15
    (PSEL && !PENABLE && !ok_addr) |=> PSLVERR)
    else $error("unmapped access without error");
  a_trig_expires: assert property (@(posedge CLOCK) disable iff (!NRST) // R17
    (ctrl[fic_pkg::BIT_TRIG] && state == fic_pkg::FIC_IDLE && tmr == 16'h0)
    |=> !ctrl[fic_pkg::BIT_TRIG])
    else $error("trigger kept after timeout");
  a_mode_erase: assert property (@(posedge CLOCK) disable iff (!NRST) // R16
    (state == fic_pkg::FIC_IDLE && !clr_bit && ctrl[fic_pkg::BIT_WT]
    && ctrl[fic_pkg::BIT_EWEN] && ctrl[6:4] == fic_pkg::MODE_ERASE)
    |=> state == fic_pkg::FIC_ERASE)
    else $error("erase mode not started");
  a_mode_write: assert property (@(posedge CLOCK) disable iff (!NRST) // R4
    (state == fic_pkg::FIC_IDLE && !clr_bit && ctrl[fic_pkg::BIT_WT]
    && ctrl[fic_pkg::BIT_EWEN] && ctrl[6:4] == fic_pkg::MODE_WRITE)
    |=> state == fic_pkg::FIC_WRITE && ctrl[fic_pkg::BIT_WT])
    else $error("write mode not started");
  a_read_lands: assert property (@(posedge CLOCK) disable iff (!NRST) // R20
    state == fic_pkg::FIC_READ |=> dpair[0] == $past(flash_mem[faddr]))
    else $error("read word not in pair zero");
  a_rd_needs_en: assert property (@(posedge CLOCK) disable iff (!NRST) // R5
    state == fic_pkg::FIC_READ |-> $past(ctrl[fic_pkg::BIT_RDEN]))
    else $error("read without read enable");
  a_busy_follows: assert property (@(posedge CLOCK) disable iff (!NRST) // R4
    BUSY == ($past(state) != fic_pkg::FIC_IDLE))
    else $error("busy flag out of step");
  a_erase_fills: assert property (@(posedge CLOCK) disable iff (!NRST) // R1
    (state == fic_pkg::FIC_ERASE && tmr == 16'h0)
    |=> flash_mem[{$past(page), 5'h0}] == fic_pkg::ERASED_WORD)
    else $error("page not erased");
  a_clear_starts: assert property (@(posedge CLOCK) disable iff (!NRST) // R7
    (state == fic_pkg::FIC_IDLE && clr_bit) |=> state == fic_pkg::FIC_CLEAR)
    else $error("buffer clear not started");
endmodule
`default_nettype wire

/* File: testbench/flash_iap_controller_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_iap_controller_bench;
  typedef struct packed {logic [7:0] addr; logic [7:0] wval; logic [7:0] rexp;} fic_row_type;
  logic CLOCK = 1'b0;
  logic NRST = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [31:0] PADDR = 32'h0;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic CHIP_RESET;
  logic BUSY;
  int err_total = 0;
  int tests_run = 0;
  int resets = 0;
  logic [7:0] q;
  logic [7:0] hi;
  logic serr;
  fic_row_type rows [7] = '{'{8'h0c, 8'ha5, 8'ha5}, '{8'h10, 8'hff, 8'h0f},
    '{8'h04, 8'h12, 8'h12}, '{8'h00, 8'h80, 8'h00}, '{8'h08, 8'hfe, 8'h00},
    '{8'h14, 8'h3c, 8'h3c}, '{8'h30, 8'h77, 8'h77}};
  logic [7:0] pats [6] = '{fic_pkg::PAT1[7:0], fic_pkg::PAT1[15:8], fic_pkg::PAT2[7:0],
    fic_pkg::PAT2[15:8], fic_pkg::PAT3[7:0], fic_pkg::PAT3[15:8]};
  logic [7:0] raddr [3] = '{8'h5d, 8'h5e, 8'h5f};
  logic [15:0] rexp [3] = '{fic_pkg::ERASED_WORD, 16'h1234, 16'h5678};

  fic_ctrl i_fic_ctrl (
    .CLOCK(CLOCK),
    .NRST(NRST),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA),
    .PRDATA(PRDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .CHIP_RESET(CHIP_RESET),
    .BUSY(BUSY)
  );

  always #50 CLOCK = ~CLOCK;

  always @(posedge CLOCK)
  begin
    if (CHIP_RESET === 1'b1)
      resets <= resets + 1;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic wrap_up;
    if (err_total == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] r);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= {24'h0, a};
    PWDATA <= {24'h0, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    @(posedge CLOCK);
    while (PREADY !== 1'b1)
      @(posedge CLOCK);
    r = PRDATA[7:0];
    serr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // read a register until the masked bits fall, bounded
  task automatic poll(input logic [7:0] a, input logic [7:0] m);
    int n;
    n = 0;
    q = m;
    while ((q & m) !== 8'h00 && n < 700)
    begin
      apb(a, 1'b0, 8'h00, q);
      n++;
    end
    chk(16'(n < 700), 16'h1);
  endtask

  initial
  begin
    repeat (20000) @(posedge CLOCK);
    err_total++;
    wrap_up;
  end

  initial
  begin
    repeat (12) @(posedge CLOCK);
    NRST <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].addr, 1'b0, 8'h00, q);
      chk(16'(q), 16'h0);
      apb(rows[i].addr, 1'b1, rows[i].wval, q);
      apb(rows[i].addr, 1'b0, 8'h00, q);
      chk(16'(q), 16'(rows[i].rexp));
    end
    // buffer load refused while erase/write is disabled
    apb(8'h18, 1'b1, 8'h5a, q);
    apb(8'h0c, 1'b0, 8'h00, q);
    chk(16'(q), 16'h00a5);
    apb(8'hfc, 1'b0, 8'h00, q);
    chk(16'(serr), 16'h1);
    // enable procedure
    apb(8'h00, 1'b1, 8'h68, q);
    for (int i = 0; i < 6; i++)
      apb(8'h1c + 8'(4 * i), 1'b1, pats[i], q);
    apb(8'h00, 1'b0, 8'h00, q);
    chk(16'(q & 8'h88), 16'h0080);
    apb(8'h08, 1'b1, 8'h01, q);
    poll(8'h08, 8'h01);
    // page erase of page 2
    apb(8'h10, 1'b1, 8'h00, q);
    apb(8'h0c, 1'b1, 8'h5e, q);
    apb(8'h00, 1'b1, 8'h94, q);
    repeat (2) @(posedge CLOCK);
    @(negedge CLOCK);
    chk(16'(BUSY), 16'h1);
    poll(8'h00, 8'h04);
    chk(16'(BUSY), 16'h0);
    // two words into the buffer, address holds at the last word
    apb(8'h0c, 1'b1, 8'h5e, q);
    apb(8'h14, 1'b1, 8'h34, q);
    apb(8'h18, 1'b1, 8'h12, q);
    apb(8'h0c, 1'b0, 8'h00, q);
    chk(16'(q), 16'h005f);
    apb(8'h14, 1'b1, 8'h78, q);
    apb(8'h18, 1'b1, 8'h56, q);
    apb(8'h0c, 1'b0, 8'h00, q);
    chk(16'(q), 16'h005f);
    apb(8'h00, 1'b1, 8'h84, q);
    poll(8'h00, 8'h04);
    // read back single words
    for (int i = 0; i < 3; i++)
    begin
      apb(8'h0c, 1'b1, raddr[i], q);
      apb(8'h00, 1'b1, 8'hb2, q);
      apb(8'h00, 1'b1, 8'hb3, q);
      poll(8'h00, 8'h01);
      apb(8'h18, 1'b0, 8'h00, hi);
      apb(8'h14, 1'b0, 8'h00, q);
      chk({hi, q}, rexp[i]);
    end
    // a load discarded by a manual clear leaves the page untouched
    apb(8'h0c, 1'b1, 8'h5d, q);
    apb(8'h14, 1'b1, 8'h00, q);
    apb(8'h18, 1'b1, 8'h00, q);
    apb(8'h08, 1'b1, 8'h01, q);
    poll(8'h08, 8'h01);
    apb(8'h00, 1'b1, 8'h84, q);
    poll(8'h00, 8'h04);
    apb(8'h0c, 1'b1, 8'h5d, q);
    apb(8'h00, 1'b1, 8'hb2, q);
    apb(8'h00, 1'b1, 8'hb3, q);
    poll(8'h00, 8'h01);
    apb(8'h18, 1'b0, 8'h00, hi);
    apb(8'h14, 1'b0, 8'h00, q);
    chk({hi, q}, fic_pkg::ERASED_WORD);
    apb(8'h00, 1'b1, 8'h00, q);
    apb(8'h00, 1'b0, 8'h00, q);
    chk(16'(q), 16'h0);
    // wrong pattern: trigger times out, status stays clear
    apb(8'h1c, 1'b1, 8'h00, q);
    apb(8'h00, 1'b1, 8'h68, q);
    poll(8'h00, 8'h08);
    chk(16'(q), 16'h0060);
    apb(8'h04, 1'b1, 8'h54, q);
    apb(8'h04, 1'b1, fic_pkg::CHIP_RST_KEY, q);
    repeat (3) @(posedge CLOCK);
    chk(16'(resets), 16'h1);
    // reset in mid-run returns the address to zero
    NRST <= 1'b0;
    repeat (2) @(posedge CLOCK);
    NRST <= 1'b1;
    apb(8'h0c, 1'b0, 8'h00, q);
    chk(16'(q), 16'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
